// >>> crma_partner.sv
// remote requester model: sends request messages and sinks reply tokens
// assumes the block's token ports, one clock and a synchronous reset
`timescale 1ns/1ps
module crma_partner
  import crma_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  output logic             in_valid,
  output logic             in_ctrl,
  output logic [7:0]       in_data,
  input  wire logic        in_ready,
  input  wire logic        out_valid,
  input  wire logic        out_ctrl,
  input  wire logic [7:0]  out_data,
  input  wire logic [23:0] out_dest,
  output logic             out_ready
);
  // requester-side address forms; the block itself never sees them
  localparam logic [11:0] TILE_BANK = 12'h20c;
  localparam logic [11:0] NODE_BANK = 12'h30c;
  localparam logic [7:0]  PS_RES    = 8'h0b;
  localparam logic [19:0] DEST_ID   = 20'h00001;  // value arbitrary
  logic        slow;
  logic        to_node;
  logic [31:0] chan_dest;
  logic [8:0]  rx[$];
  logic [23:0] rx_dest;

  // status resource id: register number moved up one byte
  function automatic logic [23:0] ps_id(input logic [15:0] rn);
    return {rn, PS_RES};
  endfunction

  // quiet lines at time zero
  initial begin
    in_valid  = 1'b0;
    in_ctrl   = 1'b0;
    in_data   = 8'h00;
    out_ready = 1'b0;
    slow      = 1'b0;
    to_node   = 1'b0;
    chan_dest = 32'h0;
  end

  // one token, held until the block takes it
  task automatic send(input logic c, input logic [7:0] d);
    in_valid <= 1'b1;
    in_ctrl  <= c;
    in_data  <= d;
    @(posedge ref_clk);
    while (!in_ready) @(posedge ref_clk);
  endtask

  // whole message; early drops the data field to make it malformed
  task automatic request(input logic [7:0] op, input logic [23:0] ret,
                         input logic [15:0] rn, input logic [31:0] dat, input logic early);
    chan_dest = {DEST_ID, (to_node ? NODE_BANK : TILE_BANK)};
    send(1'b1, op);
    for (int i = 2; i >= 0; i--) send(1'b0, ret[8*i +: 8]);
    for (int i = 1; i >= 0; i--) send(1'b0, rn[8*i +: 8]);
    if (op == CT_WRITE && !early) begin
      for (int i = 3; i >= 0; i--) send(1'b0, dat[8*i +: 8]);
    end
    send(1'b1, CT_END);
    in_valid <= 1'b0;
    in_data  <= ~in_data;  // released line must not look like a stale token
  endtask

  // reply sink; slow mode stalls every other cycle to test holding
  always @(posedge ref_clk) begin
    out_ready <= rst ? 1'b0 : (slow ? ~out_ready : 1'b1);
    if (!rst && out_valid && out_ready) begin
      rx.push_back({out_ctrl, out_data});
      rx_dest <= out_dest;
    end
  end
endmodule

// >>> crma_pkg.sv
// constants and types for the config register message access block
// assumes a token stream of 8-bit data or control tokens, msb first
// Notes on behaviour
// - write request: ctrl 192, 24-bit return, 16-bit reg, 32-bit data, ctrl 1
// - write reply: ctrl 3 then ctrl 1 on success, ctrl 4 then 1 on failure
// - read request: ctrl 193, 24-bit return, 16-bit reg, ctrl 1
// - read reply: ctrl 3, 32-bit data, ctrl 1; failure gives ctrl 4, 1
// - every request carries 24-bit reply destination; reply goes there
// - write with low 8 return bits all ones: do write, send no reply
// - multi-byte fields travel most significant byte first
package crma_pkg;
  localparam logic [7:0] CT_WRITE = 8'hc0;  // 192
  localparam logic [7:0] CT_READ  = 8'hc1;  // 193
  localparam logic [7:0] CT_END   = 8'h01;
  localparam logic [7:0] CT_ACK   = 8'h03;
  localparam logic [7:0] CT_NACK  = 8'h04;
  localparam logic [7:0] NO_REPLY = 8'hff;
  localparam int unsigned RET_BYTES = 3;
  localparam int unsigned REG_BYTES = 2;
  localparam int unsigned DAT_BYTES = 4;
  typedef enum logic [3:0] {
    CRMA_IDLE, CRMA_RET, CRMA_REG, CRMA_DAT, CRMA_END, CRMA_DRAIN,
    CRMA_ACC, CRMA_WAIT, CRMA_HDR, CRMA_DOUT, CRMA_TAIL
  } crma_state_t;
endpackage

// >>> crma_regfile.sv
// small register store holding the configuration words
// assumes one access per cycle; read data registered
`timescale 1ns/1ps
module crma_regfile #(
  parameter int unsigned NREGS = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);
  logic [31:0] mem_ff [NREGS];
  // memory array has no reset to keep it a plain ram
  always_ff @(posedge ref_clk) begin
    if (we && addr < 16'(NREGS)) begin
      mem_ff[addr[$clog2(NREGS)-1:0]] <= wdata;
    end
  end
  // read register cleared by reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= mem_ff[addr[$clog2(NREGS)-1:0]];
    end
  end
endmodule

// >>> crma_top.sv
// token message interpreter for configuration register reads and writes
// assumes one token per in_valid cycle; out_ready back-pressures replies
`timescale 1ns/1ps
module crma_top
  import crma_pkg::*;
#(
  parameter int unsigned NREGS = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        in_valid,
  input  wire logic        in_ctrl,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  output logic             out_valid,
  output logic             out_ctrl,
  output logic [7:0]       out_data,
  output logic [23:0]      out_dest,
  input  wire logic        out_ready
);
  crma_state_t state_ff, nxt_state;
  logic [23:0] ret_ff, nxt_ret;
  logic [15:0] reg_ff, nxt_reg;
  logic [31:0] dat_ff, nxt_dat;
  logic [2:0]  cnt_ff, nxt_cnt;
  logic        is_wr_ff, nxt_is_wr;
  logic        bad_ff, nxt_bad;
  logic        in_ready_nxt, ov_nxt, oc_nxt;
  logic [7:0]  od_nxt;
  logic [23:0] odst_nxt;
  logic        rf_we;
  logic [31:0] rf_rdata;
  logic        take;

  assign take = in_valid && in_ready;
  // range test here too: bad_ff only learns of an unknown register a cycle later
  assign rf_we = (state_ff == CRMA_ACC) && is_wr_ff && !bad_ff && (reg_ff < 16'(NREGS));

  crma_regfile #(.NREGS(NREGS)) u_rf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (rf_we),
    .addr    (reg_ff),
    .wdata   (dat_ff),
    .rdata   (rf_rdata)
  );

  // request parse and reply sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_ret = ret_ff;
    nxt_reg = reg_ff;
    nxt_dat = dat_ff;
    nxt_cnt = cnt_ff;
    nxt_is_wr = is_wr_ff;
    nxt_bad = bad_ff;
    in_ready_nxt = 1'b0;
    ov_nxt = out_valid;
    oc_nxt = out_ctrl;
    od_nxt = out_data;
    odst_nxt = out_dest;
    case (state_ff)
      CRMA_IDLE: begin
        in_ready_nxt = 1'b1;
        if (take) begin
          nxt_cnt = 3'h0;
          nxt_bad = 1'b0;
          if (in_ctrl && (in_data == CT_WRITE || in_data == CT_READ)) begin
            nxt_is_wr = (in_data == CT_WRITE);
            nxt_state = CRMA_RET;
          end
        end
      end
      CRMA_RET, CRMA_REG, CRMA_DAT: begin
        in_ready_nxt = 1'b1;
        if (take) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (in_ctrl) begin
            // early end token: malformed, answer failure
            nxt_bad = 1'b1;
            in_ready_nxt = 1'b0;
            nxt_state = (in_data == CT_END) ? CRMA_ACC : CRMA_DRAIN;
          end else if (state_ff == CRMA_RET) begin
            nxt_ret = {ret_ff[15:0], in_data};  // msb first
            if (cnt_ff == 3'(RET_BYTES - 1)) begin
              nxt_cnt = 3'h0;
              nxt_state = CRMA_REG;
            end
          end else if (state_ff == CRMA_REG) begin
            nxt_reg = {reg_ff[7:0], in_data};
            if (cnt_ff == 3'(REG_BYTES - 1)) begin
              nxt_cnt = 3'h0;
              nxt_state = is_wr_ff ? CRMA_DAT : CRMA_END;
            end
          end else begin
            nxt_dat = {dat_ff[23:0], in_data};
            if (cnt_ff == 3'(DAT_BYTES - 1)) begin
              nxt_state = CRMA_END;
            end
          end
        end
      end
      CRMA_END: begin
        in_ready_nxt = 1'b1;
        if (take) begin
          if (!(in_ctrl && in_data == CT_END)) begin
            nxt_bad = 1'b1;
          end
          in_ready_nxt = 1'b0;
          nxt_state = (in_ctrl && in_data == CT_END) ? CRMA_ACC : CRMA_DRAIN;
        end
      end
      CRMA_DRAIN: begin
        // discard to the closing end token of a broken message
        in_ready_nxt = 1'b1;
        if (take && in_ctrl && in_data == CT_END) begin
          in_ready_nxt = 1'b0;
          nxt_state = CRMA_ACC;
        end
      end
      CRMA_ACC: begin
        if (nxt_reg >= 16'(NREGS)) begin
          nxt_bad = 1'b1;
        end
        if (reg_ff >= 16'(NREGS)) begin
          nxt_bad = 1'b1;  // unknown register fails
        end
        nxt_state = CRMA_WAIT;
      end
      CRMA_WAIT: begin
        // read data settles in the store's output register
        if (is_wr_ff && ret_ff[7:0] == NO_REPLY) begin
          nxt_state = CRMA_IDLE;  // silent write
          in_ready_nxt = 1'b1;
        end else begin
          ov_nxt = 1'b1;
          oc_nxt = 1'b1;
          od_nxt = bad_ff ? CT_NACK : CT_ACK;
          odst_nxt = ret_ff;
          nxt_dat = rf_rdata;
          nxt_cnt = 3'h0;
          nxt_state = CRMA_HDR;
        end
      end
      CRMA_HDR, CRMA_DOUT: begin
        if (out_ready) begin
          if (!bad_ff && !is_wr_ff && !(state_ff == CRMA_DOUT && cnt_ff == 3'(DAT_BYTES))) begin
            oc_nxt = 1'b0;
            od_nxt = dat_ff[31:24];
            nxt_dat = {dat_ff[23:0], 8'h00};
            nxt_cnt = cnt_ff + 3'h1;
            nxt_state = CRMA_DOUT;
            if (cnt_ff == 3'(DAT_BYTES - 1)) begin
              nxt_cnt = 3'(DAT_BYTES);
            end
            if (state_ff == CRMA_DOUT && cnt_ff == 3'(DAT_BYTES)) begin
              nxt_state = CRMA_TAIL;
            end
          end else begin
            oc_nxt = 1'b1;
            od_nxt = CT_END;
            nxt_state = CRMA_TAIL;
          end
        end
      end
      CRMA_TAIL: begin
        if (out_ready) begin
          ov_nxt = 1'b0;
          nxt_state = CRMA_IDLE;
          in_ready_nxt = 1'b1;
        end
      end
      default: begin
        nxt_state = CRMA_IDLE;
      end
    endcase
  end

  // registers for state and outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= CRMA_IDLE;
      ret_ff <= 24'h0;
      reg_ff <= 16'h0;
      dat_ff <= 32'h0;
      cnt_ff <= 3'h0;
      is_wr_ff <= 1'b0;
      bad_ff <= 1'b0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_ctrl <= 1'b0;
      out_data <= 8'h00;
      out_dest <= 24'h0;
    end else begin
      state_ff <= nxt_state;
      ret_ff <= nxt_ret;
      reg_ff <= nxt_reg;
      dat_ff <= nxt_dat;
      cnt_ff <= nxt_cnt;
      is_wr_ff <= nxt_is_wr;
      bad_ff <= nxt_bad;
      in_ready <= in_ready_nxt;
      out_valid <= ov_nxt;
      out_ctrl <= oc_nxt;
      out_data <= od_nxt;
      out_dest <= odst_nxt;
    end
  end

  // first reply token is ack or nack, a control token
  a_first_token: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CRMA_WAIT && !(is_wr_ff && ret_ff[7:0] == NO_REPLY)) |=>
    out_valid && out_ctrl && out_data == (bad_ff ? CT_NACK : CT_ACK))
    else $error("bad first reply token");
  a_silent_write: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CRMA_WAIT && is_wr_ff && ret_ff[7:0] == NO_REPLY) |=> !out_valid[*2])
    else $error("reply sent for suppressed write");
  a_reply_dest: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(out_valid) |-> out_dest == ret_ff)
    else $error("reply destination wrong");
  a_reply_tail: assert property (@(posedge ref_clk) disable iff (rst)
    (out_valid && out_ready && state_ff == CRMA_TAIL) |-> out_ctrl && out_data == CT_END)
    else $error("reply not closed by end token");
  a_write_commit: assert property (@(posedge ref_clk) disable iff (rst)
    rf_we |-> (is_wr_ff && reg_ff < 16'(NREGS)) ##1 !bad_ff)
    else $error("write committed outside map");
  a_bad_nack: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CRMA_ACC && reg_ff >= 16'(NREGS)) |=> ##1 (out_valid -> out_data == CT_NACK))
    else $error("unknown register not failed");
  a_read_data: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CRMA_HDR && out_ready && !bad_ff && !is_wr_ff) |=> !out_ctrl)
    else $error("read data missing");
  a_ret_shift: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == CRMA_RET && take && !in_ctrl) |=> ret_ff[7:0] == $past(in_data))
    else $error("return field not msb first");
  c_read: cover property (@(posedge ref_clk) state_ff == CRMA_DOUT);
  c_write: cover property (@(posedge ref_clk) rf_we);
  c_nack: cover property (@(posedge ref_clk) out_valid && out_data == CT_NACK);
endmodule

// >>> testbench.sv
// self-checking bench for the config register message interpreter
// assumes the requester model and a 16-entry register store
`timescale 1ns/1ps
module testbench;
  import crma_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        in_valid;
  logic        in_ctrl;
  logic [7:0]  in_data;
  logic        in_ready;
  logic        out_valid;
  logic        out_ctrl;
  logic [7:0]  out_data;
  logic [23:0] out_dest;
  logic        out_ready;
  logic [8:0]  none[$];
  int          bad_count;
  int          n_compared;

  crma_top #(.NREGS(16)) u_crma_top (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
    .in_ctrl(in_ctrl), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_ctrl(out_ctrl), .out_data(out_data), .out_dest(out_dest), .out_ready(out_ready));
  crma_partner partner (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid), .in_ctrl(in_ctrl),
    .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_ctrl(out_ctrl),
    .out_data(out_data), .out_dest(out_dest), .out_ready(out_ready));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // whole reply; extra tokens show up as a length error
  task automatic await_reply(input logic [23:0] ret, input logic [8:0] exp[$]);
    for (int n = 0; n < 60 && partner.rx.size() < exp.size(); n++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    check("reply length", 32'(partner.rx.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < partner.rx.size()) begin
        check("reply token", 32'(partner.rx[i]), 32'(exp[i]));
      end
    end
    if (exp.size() > 0) begin
      check("reply dest", 32'(partner.rx_dest), 32'(ret));
    end
  endtask

  // one request, then the whole reply
  task automatic exchange(input logic [7:0] op, input logic [23:0] ret, input logic [15:0] rn,
                          input logic [31:0] dat, input logic early, input logic [8:0] exp[$]);
    partner.rx.delete();
    partner.request(op, ret, rn, dat, early);
    await_reply(ret, exp);
  endtask

  task automatic t_write_ok();
    exchange(CT_WRITE, 24'h123456, 16'h0005, 32'hcafe0123, 1'b0, '{9'h103, 9'h101});
    check("tile bank", 32'(partner.chan_dest[11:0]), 32'h0000020c);
    check("status id", 32'(partner.ps_id(16'h0005)), 32'h0000050b);
    $display("test write_ok done");
  endtask

  // reply must hold through stalls, data msb first
  task automatic t_read_slow();
    partner.slow = 1'b1;
    exchange(CT_READ, 24'habcd20, 16'h0005, 32'h0, 1'b0,
             '{9'h103, 9'h0ca, 9'h0fe, 9'h001, 9'h023, 9'h101});
    partner.slow = 1'b0;
    $display("test read_slow done");
  endtask

  // silent write still lands; last register is the boundary
  task automatic t_silent();
    partner.to_node = 1'b1;
    exchange(CT_WRITE, 24'h4321ff, 16'h000f, 32'h89abcdef, 1'b0, none);
    check("node bank", 32'(partner.chan_dest[11:0]), 32'h0000030c);
    partner.to_node = 1'b0;
    exchange(CT_READ, 24'h4321fe, 16'h000f, 32'h0, 1'b0,
             '{9'h103, 9'h089, 9'h0ab, 9'h0cd, 9'h0ef, 9'h101});
    $display("test silent done");
  endtask

  // unknown numbers and a short write all fail, back to back
  task automatic t_fail();
    exchange(CT_READ, 24'h000102, 16'h0010, 32'h0, 1'b0, '{9'h104, 9'h101});
    exchange(CT_WRITE, 24'h000103, 16'h0100, 32'h1, 1'b0, '{9'h104, 9'h101});
    exchange(CT_WRITE, 24'h000104, 16'h0002, 32'h1, 1'b1, '{9'h104, 9'h101});
    $display("test fail done");
  endtask

  // stray data byte in the end slot is drained to the end token, then fails
  task automatic t_drain();
    partner.rx.delete();
    partner.send(1'b1, CT_READ);
    for (int i = 0; i < 5; i++) partner.send(1'b0, 8'h00);  // return 000000, register 0000
    partner.send(1'b0, 8'h5a);
    partner.send(1'b1, CT_END);
    partner.in_valid <= 1'b0;
    await_reply(24'h000000, '{9'h104, 9'h101});
    $display("test drain done");
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reset for 20 cycles, then the scenarios in turn
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_write_ok();
    t_read_slow();
    t_silent();
    t_fail();
    t_drain();
    conclude();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    conclude();
  end
endmodule
